// *** design/ascp_pkg.sv ***
// Purpose: Shared constants and types for the amplifier serial control port
// Assumes: 24-bit access, 8-bit command then 16-bit data, MSB first
// Notes:   Read flag is command bit 7; remaining command bits are ignored
package ascp_pkg;
  localparam int          CMD_BITS      = 8;
  localparam int          DATA_BITS     = 16;
  localparam int          FRAME_BITS    = CMD_BITS + DATA_BITS;
  localparam int          CNT_W         = 5;
  localparam int          READ_FLAG_POS = 7;
  // Control word field positions
  localparam int          ATTEN_LSB     = 0;
  localparam int          ATTEN_W       = 4;
  localparam int          GAIN_POS      = 4;
  localparam int          FILT_LSB      = 6;
  localparam int          FILT_W        = 3;
  localparam int          AUX_OFF_POS   = 10;
  // Value after reset: 20 MHz, full power, low gain, -20 dB
  localparam logic [15:0] CTRL_RESET    = 16'h000A;
  // Bits that must be written as zero (D5, D9, D11..D14)
  localparam logic [15:0] CTRL_ZERO_MSK = 16'h7A20;
  localparam logic [3:0]  ATTEN_MAX     = 4'hA;
  localparam logic [2:0]  FILT_MAX      = 3'h5;
  // Host link clock divider: half period in system clocks
  localparam int          HALF_DIV      = 2;
  localparam int          DIV_W         = 2;
  // Host command register map (word offsets)
  localparam logic [1:0]  REG_CTRL      = 2'h0;
  localparam logic [1:0]  REG_WDATA     = 2'h1;
  localparam logic [1:0]  REG_RDATA     = 2'h2;
  localparam logic [1:0]  REG_STATUS    = 2'h3;
  localparam logic [15:0] HOST_RESET16  = 16'h0000;

  typedef enum logic [2:0] {
    H_IDLE  = 3'b001,
    H_SHIFT = 3'b010,
    H_DONE  = 3'b100
  } ascp_host_state_type;
endpackage

// *** design/ascp_if.sv ***
// Purpose: Three-wire link between host and amplifier control port
// Assumes: Data line resolved from the two output enables
// Notes:   Chip select active low; clock made by the host
`timescale 1ns/1ps
interface ascp_if;
  logic cs_n;      // Chip select, active low
  logic sclk;      // Serial clock from host
  logic sdio_h_o;  // Host drive value
  logic sdio_h_oe; // Host drive enable
  logic sdio_d_o;  // Device drive value
  logic sdio_d_oe; // Device drive enable
  logic sdio;      // Resolved line level
  // Wire level with weak pull-up when nobody drives
  assign sdio = sdio_h_oe ? sdio_h_o : (sdio_d_oe ? sdio_d_o : 1'b1);
  modport host (output cs_n, output sclk, output sdio_h_o, output sdio_h_oe, input sdio);
  modport dev  (input cs_n, input sclk, output sdio_d_o, output sdio_d_oe, input sdio);
endinterface

// *** design/ascp_device.sv ***
// Purpose: Amplifier side of the serial control port, holding the control word
// Assumes: Runs on the link clock, bit counter also cleared by chip select; power-on reset is rst on that clock
// Notes:   Data sampled on rising edge, driven on falling edge
// Notes on behaviour
// RL1 - Capture and drive data only under chip select
// RL2 - Chip select off: ignore data, release line
// RL3 - Clock edges without chip select are ignored
// RL4 - Host stops clock between accesses
// RL5 - Write is command byte then data word
// RL6 - Bits after 24 are ignored
// RL7 - Read shifts stored control word out
// RL8 - Host writes zero to reserved bits; the host sends them as written and only flags them in err_reg
// RL9 - Bit 10 turns auxiliary output off
// RL10 - Bit 4 selects high gain preamp
// RL11 - Bits 8..6 select filter bandwidth
// RL12 - Bits 3..0 set ladder attenuation
// RL13 - Reset word is hex 000A
// RL14 - Control word is writable and readable
// RL15 - Command bit 7 high means read
// RL16 - Transfer is MSB first, no gaps
`timescale 1ns/1ps
module ascp_device
  import ascp_pkg::*;
(
  ascp_if.dev        link,            // Serial link
  input  wire logic  rst,             // Power-on reset, synchronous to sclk
  output logic [15:0] ctrl_word,      // Stored control word
  output logic        aux_output_off, // Auxiliary output high impedance
  output logic        high_gain_preamp, // Preamp gain select
  output logic [2:0]  filter_sel,     // Bandwidth filter code
  output logic [3:0]  atten_sel       // Ladder attenuation code
);
  logic [CNT_W-1:0] bit_cnt_reg;
  logic [FRAME_BITS-2:0] shift_reg;
  logic             rd_reg;
  logic [15:0]      ctrl_reg;
  logic [15:0]      tx_reg;
  logic             oe_reg;

  // Bit counter; only moves under chip select and stops after 24 (see RL3) (see RL6)
  // Chip select clears it at once: the link clock is stopped between accesses
  // and so could never clear it before the next frame's first edge
  always_ff @(posedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      bit_cnt_reg <= '0;
    end else if (rst) begin
      bit_cnt_reg <= '0;
    end else if (bit_cnt_reg != CNT_W'(FRAME_BITS)) begin
      bit_cnt_reg <= bit_cnt_reg + CNT_W'(1);
    end
  end

  // Input shifter, MSB first (see RL1) (see RL16)
  always_ff @(posedge link.sclk) begin
    if (rst) begin
      shift_reg <= '0;
    end else if (!link.cs_n && bit_cnt_reg < CNT_W'(FRAME_BITS)) begin
      shift_reg <= {shift_reg[FRAME_BITS-3:0], link.sdio};
    end
  end

  // Read flag latched from first command bit (see RL15)
  always_ff @(posedge link.sclk) begin
    if (rst) begin
      rd_reg <= 1'b0;
    end else if (!link.cs_n && bit_cnt_reg == CNT_W'(0)) begin
      rd_reg <= link.sdio;
    end
  end

  // Control word load on last write bit (see RL5) (see RL13) (see RL14)
  always_ff @(posedge link.sclk) begin
    if (rst) begin
      ctrl_reg <= CTRL_RESET;
    end else if (!link.cs_n && !rd_reg && bit_cnt_reg == CNT_W'(FRAME_BITS-1)) begin
      ctrl_reg <= {shift_reg[DATA_BITS-2:0], link.sdio};
    end
  end

  // Read driver: launch on falling edge; host takes each bit at the next falling edge (see RL7) (see RL2)
  always_ff @(negedge link.sclk) begin
    if (rst || link.cs_n) begin
      oe_reg <= 1'b0;
      tx_reg <= '0;
    end else if (rd_reg && bit_cnt_reg == CNT_W'(CMD_BITS)) begin
      oe_reg <= 1'b1;
      tx_reg <= ctrl_reg;
    end else if (oe_reg && bit_cnt_reg < CNT_W'(FRAME_BITS)) begin
      tx_reg <= {tx_reg[14:0], 1'b0};
    end else begin
      oe_reg <= 1'b0;
    end
  end

  // Release the line at once when chip select falls away (see RL2)
  assign link.sdio_d_oe = oe_reg & ~link.cs_n;
  assign link.sdio_d_o  = tx_reg[15];

  // Field decode (see RL9) (see RL10) (see RL11) (see RL12)
  assign ctrl_word        = ctrl_reg;
  assign aux_output_off   = ctrl_reg[AUX_OFF_POS];
  assign high_gain_preamp = ctrl_reg[GAIN_POS];
  assign filter_sel       = ctrl_reg[FILT_LSB +: FILT_W];
  assign atten_sel        = ctrl_reg[ATTEN_LSB +: ATTEN_W];
endmodule

// *** design/ascp_host.sv ***
// Purpose: Host controller driving the amplifier control port
// Assumes: Software port with read data one cycle after the read strobe
// Notes:   Link clock divided from clock; stopped between accesses
`timescale 1ns/1ps
module ascp_host
  import ascp_pkg::*;
(
  input  wire logic        clock,  // System clock
  input  wire logic        rst,    // Synchronous reset
  input  wire logic [1:0]  addr,   // Register word address
  input  wire logic [15:0] wdata,  // Write data
  input  wire logic        wr,     // Write strobe
  input  wire logic        rd,     // Read strobe
  output logic      [15:0] rdata,  // Read data, cycle after rd
  ascp_if.host             link    // Serial link
);
  ascp_host_state_type state_reg;
  logic [DIV_W-1:0] div_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [23:0] sh_reg;
  logic [15:0] wdata_reg, rdres_reg;
  logic        read_reg, sclk_reg, csn_reg, oe_reg, busy_reg, err_reg;
  logic        sdio_s1, sdio_s2;
  logic        start;

  assign start = wr && addr == REG_CTRL && state_reg == H_IDLE;

  // Two-stage synchroniser for the returned data line
  always_ff @(posedge clock) begin
    sdio_s1 <= link.sdio;
    sdio_s2 <= sdio_s1;
  end

  // Data word to send; flag reserved bits set or codes out of range (see RL8) (see RL12)
  always_ff @(posedge clock) begin
    if (rst) begin
      wdata_reg <= HOST_RESET16;
      err_reg   <= 1'b0;
    end else if (wr && addr == REG_WDATA) begin
      wdata_reg <= wdata;
      err_reg   <= |(wdata & CTRL_ZERO_MSK) || wdata[3:0] > ATTEN_MAX || wdata[8:6] > FILT_MAX;
    end
  end

  // Transfer sequencer: 24 clocks per access, clock held low otherwise (see RL4) (see RL5)
  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= H_IDLE;
      div_reg <= '0;
      cnt_reg <= '0;
      sh_reg <= '0;
      read_reg <= 1'b0;
      sclk_reg <= 1'b0;
      csn_reg <= 1'b1;
      oe_reg <= 1'b0;
      rdres_reg <= HOST_RESET16;
    end else begin
      unique case (state_reg)
        H_IDLE: begin
          if (start) begin
            read_reg <= wdata[0];
            // Command bit 7 flags a read, MSB first (see RL15) (see RL16)
            sh_reg <= {wdata[0], 7'h00, wdata_reg};
            csn_reg <= 1'b0;
            oe_reg <= 1'b1;
            cnt_reg <= '0;
            div_reg <= '0;
            state_reg <= H_SHIFT;
          end
        end
        H_SHIFT: begin
          div_reg <= div_reg + DIV_W'(1);
          if (div_reg == DIV_W'(HALF_DIV-1)) begin
            div_reg <= '0;
            sclk_reg <= ~sclk_reg;
            if (sclk_reg) begin
              // Falling edge: advance data
              sh_reg <= {sh_reg[22:0], 1'b0};
              cnt_reg <= cnt_reg + CNT_W'(1);
              if (read_reg && cnt_reg == CNT_W'(CMD_BITS-1)) begin
                oe_reg <= 1'b0;
              end
              if (cnt_reg == CNT_W'(FRAME_BITS-1)) begin
                state_reg <= H_DONE;
              end
              // Returned bit, launched one link period ago, seen through the
              // synchroniser; its two clocks of delay limit the link rate
              if (read_reg && cnt_reg >= CNT_W'(CMD_BITS)) begin
                rdres_reg <= {rdres_reg[14:0], sdio_s2};
              end
            end
          end
        end
        H_DONE: begin
          csn_reg <= 1'b1;
          oe_reg <= 1'b0;
          state_reg <= H_IDLE;
        end
        default: state_reg <= H_IDLE;
      endcase
    end
  end

  assign busy_reg = state_reg != H_IDLE;

  // Register read port
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata <= HOST_RESET16;
    end else if (rd) begin
      unique case (addr)
        REG_CTRL:   rdata <= {15'h0000, busy_reg};
        REG_WDATA:  rdata <= wdata_reg;
        REG_RDATA:  rdata <= rdres_reg;
        REG_STATUS: rdata <= {14'h0000, err_reg, busy_reg};
      endcase
    end else begin
      rdata <= HOST_RESET16;
    end
  end

  assign link.cs_n      = csn_reg;
  assign link.sclk      = sclk_reg;
  assign link.sdio_h_o  = sh_reg[23];
  assign link.sdio_h_oe = oe_reg;
endmodule

// *** test/ascp_properties.sv ***
// Purpose: Link properties for the amplifier serial control port
// Assumes: Link clock is divided from clock, so clock samples it cleanly
// Notes:   Shadow word follows written data to judge read-back bits
`timescale 1ns/1ps
module ascp_properties
  import ascp_pkg::*;
(
  input wire logic clock,     // System clock
  input wire logic rst,       // Host reset
  input wire logic dev_rst,   // Device reset
  input wire logic cs_n,      // Chip select, active low
  input wire logic sclk,      // Link clock
  input wire logic sdio_h_o,  // Host drive value
  input wire logic sdio_h_oe, // Host drive enable
  input wire logic sdio_d_o,  // Device drive value
  input wire logic sdio_d_oe, // Device drive enable
  input wire logic sdio       // Resolved line
);
  logic        sclk_q_reg;
  logic [4:0]  cnt_reg;
  logic        rdbit_reg;
  logic [15:0] shadow_reg;
  logic        rise;
  assign rise = sclk & ~sclk_q_reg & ~cs_n;
  // Rising edges inside a frame; cleared by chip select so stray edges never count
  always_ff @(posedge clock) begin
    sclk_q_reg <= sclk;
    if (rst || cs_n) begin
      cnt_reg <= 5'h00;
    end else if (rise) begin
      cnt_reg <= cnt_reg + 5'h01;
    end
  end
  // First bit is the read flag; data bits of writes feed the shadow
  always_ff @(posedge clock) begin
    if (rst) begin
      rdbit_reg  <= 1'b0;
      shadow_reg <= CTRL_RESET;
    end else if (rise && cnt_reg == 5'h00) begin
      rdbit_reg <= sdio;
    end else if (rise && !rdbit_reg && cnt_reg >= 5'h08 && cnt_reg < 5'h18) begin
      shadow_reg[5'h17 - cnt_reg] <= sdio;
    end
  end
  chk_dev_release: assert property (@(posedge clock) disable iff (rst || dev_rst)
    cs_n |-> !sdio_d_oe) else $error("device drives while deselected");
  chk_no_clash: assert property (@(posedge clock) disable iff (rst || dev_rst)
    !(sdio_h_oe && sdio_d_oe)) else $error("both ends drive the line");
  chk_clk_idle: assert property (@(posedge clock) disable iff (rst)
    cs_n |-> !sclk) else $error("link clock runs outside a frame");
  chk_frame_len: assert property (@(posedge clock) disable iff (rst)
    $rose(cs_n) |-> cnt_reg == 5'h18) else $error("frame is not 24 bits");
  chk_drive_window: assert property (@(posedge clock) disable iff (rst || dev_rst)
    sdio_d_oe |-> rdbit_reg && cnt_reg >= 5'h08) else $error("device drives outside read data");
  chk_readback_bit: assert property (@(posedge clock) disable iff (rst || dev_rst)
    rise && rdbit_reg && cnt_reg >= 5'h08 && cnt_reg < 5'h18 |-> sdio == shadow_reg[5'h17 - cnt_reg])
    else $error("read-back bit differs");
  chk_host_yield: assert property (@(posedge clock) disable iff (rst)
    !cs_n && rdbit_reg && cnt_reg >= 5'h09 |-> !sdio_h_oe) else $error("host drives in read data");
  chk_clk_shape: assert property (@(posedge clock) disable iff (rst)
    $rose(sclk) |=> sclk ##1 !sclk) else $error("link clock pulse width wrong");
endmodule

// *** test/amp_serial_control_port_tb.sv ***
// Purpose: Self-checking bench joining host and device ends
// Assumes: Device reset is clocked by a throw-away read frame
// Notes:   Model word is an integer updated at each write
`timescale 1ns/1ps
module amp_serial_control_port_tb;
  import ascp_pkg::*;
  logic        clock;
  logic        rst;
  logic        dev_rst;
  logic [1:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic [15:0] ctrl_word;
  logic        aux_output_off;
  logic        high_gain_preamp;
  logic [2:0]  filter_sel;
  logic [3:0]  atten_sel;
  logic [15:0] lfsr;
  logic [15:0] got;
  logic [15:0] w;
  int          fails;
  int          samples_checked;
  int          model;
  ascp_if link();
  ascp_host ascp_host_inst (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .link(link));
  ascp_device ascp_device_inst (.link(link), .rst(dev_rst), .ctrl_word(ctrl_word),
    .aux_output_off(aux_output_off), .high_gain_preamp(high_gain_preamp),
    .filter_sel(filter_sel), .atten_sel(atten_sel));
  ascp_properties ascp_properties_inst (.clock(clock), .rst(rst), .dev_rst(dev_rst),
    .cs_n(link.cs_n), .sclk(link.sclk), .sdio_h_o(link.sdio_h_o), .sdio_h_oe(link.sdio_h_oe),
    .sdio_d_o(link.sdio_d_o), .sdio_d_oe(link.sdio_d_oe), .sdio(link.sdio));
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] seen);
    samples_checked++;
    if (exp !== seen) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One strobe cycle; read data is taken in the single cycle it stands
  task automatic bus(input logic [1:0] a, input logic [15:0] d, input logic is_wr);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= is_wr;
    rd    <= !is_wr;
    @(posedge clock);
    wr <= 1'b0;
    rd <= 1'b0;
    @(negedge clock);
    got = rdata;
  endtask
  // Full access: load word, start, poll busy under a bound, fetch read data
  task automatic access(input logic rd_op, input logic [15:0] word);
    int n;
    n = 0;
    bus(REG_WDATA, word, 1'b1);
    bus(REG_CTRL, {15'h0000, rd_op}, 1'b1);
    do begin
      bus(REG_STATUS, 16'h0000, 1'b0);
      n++;
    end while (got[0] !== 1'b0 && n < 200);
    if (n >= 200) begin
      fails++;
      test_done();
    end
    check("status", 16'h0000, got);
    bus(REG_RDATA, 16'h0000, 1'b0);
  endtask
  task automatic check_word();
    check("rdata", 16'(model), got);
    check("ctrl_word", 16'(model), ctrl_word);
    check("fields", {5'h00, model[10], model[4], model[8:6], model[3:0]},
      {5'h00, aux_output_off, high_gain_preamp, filter_sel, atten_sel});
  endtask
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    rst = 1'b1;
    dev_rst = 1'b1;
    addr = 2'h0;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    lfsr = 16'h0054;
    fails = 0;
    samples_checked = 0;
    model = CTRL_RESET;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    access(1'b1, 16'h0000);
    @(posedge clock);
    dev_rst <= 1'b0;
    access(1'b1, 16'h0000);
    check_word();
    $display("test reset value done");
    // Host flags a reserved bit, an attenuation code and a filter code out of range
    bus(REG_WDATA, 16'h0020, 1'b1);
    bus(REG_STATUS, 16'h0000, 1'b0);
    check("status", 16'h0002, got);
    bus(REG_WDATA, 16'h000B, 1'b1);
    bus(REG_WDATA, 16'h0000, 1'b0);
    check("wdata", 16'h000B, got);
    bus(REG_STATUS, 16'h0000, 1'b0);
    check("status", 16'h0002, got);
    bus(REG_WDATA, 16'h01C0, 1'b1);
    bus(REG_STATUS, 16'h0000, 1'b0);
    check("status", 16'h0002, got);
    bus(REG_WDATA, 16'h000A, 1'b1);
    bus(REG_STATUS, 16'h0000, 1'b0);
    check("status", 16'h0000, got);
    bus(REG_CTRL, 16'h0000, 1'b0);
    check("busy", 16'h0000, got);
    $display("test host flags done");
    // Every attenuation, filter, gain and power code; D15 is random don't-care
    for (int i = 0; i <= 10; i++) begin
      lfsr = lfsr_next(lfsr);
      w = {lfsr[0], 4'h0, i[1], 1'b0, 3'(i % 6), 1'b0, i[0], 4'(i)};
      model = w;
      access(1'b0, w);
      access(1'b1, 16'h0000);
      check_word();
    end
    $display("test write and read back done");
    test_done();
  end
endmodule
